// file: prmux_pkg.sv
// Constants, types and mode decoding for the port pin function multiplexer
// ===========================================================================
// Function
// - Pin 1 reset default: direction-controlled general I/O
// - Pin 1 select, input: timer external clock
// - Pin 1 analog enable overrides everything: analog
// - Analog enable kills driver and Schmitt input
// - Pin 3 select, input: capture input one B
// - Pin 3 analog enable overrides: analog/reference/amplifier
// - Pin 4 analog enable overrides: analog/reference/amplifier
// - Pin 5 select clear, resistor clear: general I/O
// - Pin 5 reset default is general I/O
// - Pin 5 select, input: no function
// - Pin 5 select, output: drive digital ground
// - Resistor select connects external oscillator resistor
// - Pin 6 select clear: direction-controlled general I/O
// - Pin 6 select set: crystal oscillator input
// - Pin 6 resets to crystal oscillator input
package prmux_pkg;

  // ===========================================================================
  // Bus and register map
  localparam int PADDR_W = 8;
  localparam int PORT_W = 8;
  localparam logic [PADDR_W-1:0] DIR_OFS = 8'h00;
  localparam logic [PADDR_W-1:0] SEL_OFS = 8'h04;
  localparam logic [PADDR_W-1:0] AEN_OFS = 8'h08;
  localparam logic [PADDR_W-1:0] OSC_OFS = 8'h0C;
  localparam logic [PADDR_W-1:0] OUT_OFS = 8'h10;
  localparam logic [PADDR_W-1:0] IN_OFS = 8'h14;
  localparam logic [PORT_W-1:0] PIN_MASK = 8'h7A;
  localparam logic [PORT_W-1:0] AEN_MASK = 8'h1A;
  localparam int ROSC_BIT = 0;
  localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
  localparam logic [PORT_W-1:0] SEL_RST = 8'h40;
  localparam logic [PORT_W-1:0] AEN_RST = 8'h00;
  localparam logic [PORT_W-1:0] OSC_RST = 8'h00;
  localparam logic [PORT_W-1:0] OUT_RST = 8'h00;

  // ===========================================================================
  // Pin positions
  localparam int PIN_TCLK = 1;
  localparam int PIN_CAP = 3;
  localparam int PIN_CMP2 = 4;
  localparam int PIN_ROSC = 5;
  localparam int PIN_XTAL = 6;

  typedef enum logic [3:0] {
    PM_GPIO_IN, PM_GPIO_OUT, PM_TCLK_IN, PM_SUBSYSTEM_MAIN_CLOCK_OUT, PM_CAP_IN, PM_CMP1_OUT,
    PM_CMP2_OUT, PM_ANALOG, PM_NONE, PM_GROUND, PM_ROSC, PM_XTAL
  } prmux_mode_t;

  // Resolves one pin's function from its own control bits, plus the shared resistor bit for pin 5
  function automatic prmux_mode_t pad_mode(input int idx, input logic dir, input logic sel,
                                           input logic aen, input logic rosc);
    prmux_mode_t gpio;
    gpio = dir ? PM_GPIO_OUT : PM_GPIO_IN;
    pad_mode = PM_NONE;
    unique case (idx)
      PIN_TCLK: pad_mode = aen ? PM_ANALOG : (sel ? (dir ? PM_SUBSYSTEM_MAIN_CLOCK_OUT : PM_TCLK_IN) : gpio);
      PIN_CAP: pad_mode = aen ? PM_ANALOG : (sel ? (dir ? PM_CMP1_OUT : PM_CAP_IN) : gpio);
      PIN_CMP2: pad_mode = aen ? PM_ANALOG : (sel ? (dir ? PM_CMP2_OUT : PM_NONE) : gpio);
      PIN_ROSC: pad_mode = rosc ? PM_ROSC : (sel ? (dir ? PM_GROUND : PM_NONE) : gpio);
      PIN_XTAL: pad_mode = sel ? PM_XTAL : gpio;
      default: pad_mode = PM_NONE;
    endcase
  endfunction

endpackage

// file: prmux_apb.sv
// APB register file holding the pin control bits
`timescale 1ns/1ps

module prmux_apb (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [prmux_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [prmux_pkg::PORT_W-1:0] in_status,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  output logic [prmux_pkg::PORT_W-1:0] dir_q,
  output logic [prmux_pkg::PORT_W-1:0] sel_q,
  output logic [prmux_pkg::PORT_W-1:0] aen_q,
  output logic [prmux_pkg::PORT_W-1:0] osc_q,
  output logic [prmux_pkg::PORT_W-1:0] out_q
);
  import prmux_pkg::*;

  logic hit;
  logic early;
  logic done;
  logic [PORT_W-1:0] rd_d;
  logic [PORT_W-1:0] wd;

  // ===========================================================================
  // Decode
  assign early = psel & penable & ~pready_q;
  assign done = psel & penable & pready_q;
  assign wd = pwdata[PORT_W-1:0];

  always_comb begin
    hit = 1'b1;
    rd_d = '0;
    unique case (paddr)
      DIR_OFS: rd_d = dir_q;
      SEL_OFS: rd_d = sel_q;
      AEN_OFS: rd_d = aen_q;
      OSC_OFS: rd_d = osc_q;
      OUT_OFS: rd_d = out_q;
      IN_OFS: rd_d = in_status;
      default: hit = 1'b0;
    endcase
  end

  // ===========================================================================
  // Handshake: one wait state so that the answer comes from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= early;
      pslverr_q <= early & ~hit;
      prdata_q <= (early & ~pwrite) ? {{(32 - PORT_W){1'b0}}, rd_d} : 32'h0000_0000;
    end
  end

  // ===========================================================================
  // Control bits; unimplemented pins stay zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= DIR_RST;
      sel_q <= SEL_RST;
      aen_q <= AEN_RST;
      osc_q <= OSC_RST;
      out_q <= OUT_RST;
    end else if (done && pwrite) begin
      unique case (paddr)
        DIR_OFS: dir_q <= wd & PIN_MASK;
        SEL_OFS: sel_q <= wd & PIN_MASK;
        AEN_OFS: aen_q <= wd & AEN_MASK;
        OSC_OFS: osc_q <= wd & OSC_RST_MASK();
        OUT_OFS: out_q <= wd & PIN_MASK;
        default: out_q <= out_q;
      endcase
    end
  end

  function automatic logic [PORT_W-1:0] OSC_RST_MASK();
    OSC_RST_MASK = '0;
    OSC_RST_MASK[ROSC_BIT] = 1'b1;
  endfunction

endmodule

// file: prmux_pad.sv
// One pad: resolved function to driver, enable, input path and analog switch
`timescale 1ns/1ps

module prmux_pad (
  input wire logic clk,
  input wire logic rst,
  input wire prmux_pkg::prmux_mode_t mode,
  input wire logic gpio_out,
  input wire logic subsystem_main_clock,
  input wire logic cmp1,
  input wire logic cmp2,
  input wire logic pad_in,
  output logic pad_out_q,
  output logic pad_oe_q,
  output logic schmitt_q,
  output logic analog_q,
  output logic in_gated
);
  import prmux_pkg::*;

  logic out_d;
  logic oe_d;
  logic schmitt_d;

  always_comb begin
    out_d = 1'b0;
    oe_d = 1'b0;
    schmitt_d = 1'b1;
    unique case (mode)
      PM_GPIO_OUT: begin
        out_d = gpio_out;
        oe_d = 1'b1;
      end
      PM_SUBSYSTEM_MAIN_CLOCK_OUT: begin
        out_d = subsystem_main_clock;
        oe_d = 1'b1;
      end
      PM_CMP1_OUT: begin
        out_d = cmp1;
        oe_d = 1'b1;
      end
      PM_CMP2_OUT: begin
        out_d = cmp2;
        oe_d = 1'b1;
      end
      PM_GROUND: oe_d = 1'b1;
      PM_ANALOG, PM_ROSC, PM_XTAL: schmitt_d = 1'b0;
      default: schmitt_d = 1'b1;
    endcase
  end

  // Digital input path is gated the moment analog use is chosen
  assign in_gated = pad_in & schmitt_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
      schmitt_q <= 1'b0;
      analog_q <= 1'b0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      schmitt_q <= schmitt_d;
      analog_q <= (mode == PM_ANALOG);
    end
  end

endmodule

// file: prmux_top.sv
// Port pin function multiplexer top: APB registers, per-pin muxing, timer routing
`timescale 1ns/1ps

module prmux_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [prmux_pkg::PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [prmux_pkg::PORT_W-1:0] PAD_IN,
  output logic [prmux_pkg::PORT_W-1:0] PAD_OUT,
  output logic [prmux_pkg::PORT_W-1:0] PAD_OE,
  output logic [prmux_pkg::PORT_W-1:0] PAD_SCHMITT_EN,
  output logic [prmux_pkg::PORT_W-1:0] ANALOG_CHANNEL_CONNECT,
  input wire logic SUBSYSTEM_MAIN_CLOCK,
  input wire logic TIMER_COMPARE_OUTPUT_ONE,
  input wire logic TIMER_COMPARE_OUTPUT_TWO,
  output logic TIMER_EXTERNAL_INPUT_CLOCK,
  output logic CAPTURE_INPUT_ONE_VARIANT_B,
  output logic CRYSTAL_OSCILLATOR_INPUT,
  output logic OSC_RESISTOR_CONNECT
);
  import prmux_pkg::*;

  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] sel_q;
  logic [PORT_W-1:0] aen_q;
  logic [PORT_W-1:0] osc_q;
  logic [PORT_W-1:0] out_q;
  logic [PORT_W-1:0] in_gated;
  prmux_mode_t mode [PORT_W];

  // ===========================================================================
  // Register file
  prmux_apb u_apb (
    .clk(CLK),
    .rst(RST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .in_status(in_gated),
    .prdata_q(PRDATA),
    .pready_q(PREADY),
    .pslverr_q(PSLVERR),
    .dir_q(dir_q),
    .sel_q(sel_q),
    .aen_q(aen_q),
    .osc_q(osc_q),
    .out_q(out_q)
  );

  // ===========================================================================
  // Pads; the mode is decoded without a clock, the pad pins then take one flop
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pad
      assign mode[i] = pad_mode(i, dir_q[i], sel_q[i], aen_q[i], osc_q[ROSC_BIT]);
      prmux_pad u_pad (
        .clk(CLK),
        .rst(RST),
        .mode(mode[i]),
        .gpio_out(out_q[i]),
        .subsystem_main_clock(SUBSYSTEM_MAIN_CLOCK),
        .cmp1(TIMER_COMPARE_OUTPUT_ONE),
        .cmp2(TIMER_COMPARE_OUTPUT_TWO),
        .pad_in(PAD_IN[i]),
        .pad_out_q(PAD_OUT[i]),
        .pad_oe_q(PAD_OE[i]),
        .schmitt_q(PAD_SCHMITT_EN[i]),
        .analog_q(ANALOG_CHANNEL_CONNECT[i]),
        .in_gated(in_gated[i])
      );
    end
  endgenerate

  // ===========================================================================
  // Routing into the timer and clock module
  // A clock passed through a flop at the system rate is only good for slow external clocks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TIMER_EXTERNAL_INPUT_CLOCK <= 1'b0;
      CAPTURE_INPUT_ONE_VARIANT_B <= 1'b0;
      CRYSTAL_OSCILLATOR_INPUT <= 1'b0;
      OSC_RESISTOR_CONNECT <= 1'b0;
    end else begin
      TIMER_EXTERNAL_INPUT_CLOCK <= (mode[PIN_TCLK] == PM_TCLK_IN) & PAD_IN[PIN_TCLK];
      CAPTURE_INPUT_ONE_VARIANT_B <= (mode[PIN_CAP] == PM_CAP_IN) & PAD_IN[PIN_CAP];
      CRYSTAL_OSCILLATOR_INPUT <= (mode[PIN_XTAL] == PM_XTAL);
      OSC_RESISTOR_CONNECT <= (mode[PIN_ROSC] == PM_ROSC);
    end
  end

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  gpio_pin1_a: assert property (
    !sel_q[1] && !aen_q[1] |=> PAD_OE[1] == $past(dir_q[1]) && PAD_OUT[1] == $past(dir_q[1] & out_q[1]))
    else $error("pin 1 general I/O wrong");
  tclk_route_a: assert property (
    sel_q[1] && !dir_q[1] && !aen_q[1] |=> TIMER_EXTERNAL_INPUT_CLOCK == $past(PAD_IN[1]) && !PAD_OE[1])
    else $error("timer clock input not routed");
  subsystem_main_clock_drive_a: assert property (
    sel_q[1] && dir_q[1] && !aen_q[1] |=> PAD_OE[1] && PAD_OUT[1] == $past(SUBSYSTEM_MAIN_CLOCK))
    else $error("main clock not driven");
  analog_pin1_a: assert property (
    aen_q[1] |=> ANALOG_CHANNEL_CONNECT[1] && !TIMER_EXTERNAL_INPUT_CLOCK)
    else $error("pin 1 analog not selected");
  analog_off_a: assert property (
    (aen_q & PIN_MASK) != 8'h00 |=> ((PAD_OE | PAD_SCHMITT_EN) & $past(aen_q)) == 8'h00)
    else $error("driver or input left on in analog use");
  capture_route_a: assert property (
    sel_q[3] && !dir_q[3] && !aen_q[3] |=> CAPTURE_INPUT_ONE_VARIANT_B == $past(PAD_IN[3]))
    else $error("capture input not routed");
  cmp1_drive_a: assert property (
    sel_q[3] && dir_q[3] && !aen_q[3] |=> PAD_OE[3] && PAD_OUT[3] == $past(TIMER_COMPARE_OUTPUT_ONE))
    else $error("compare output one not driven");
  analog_pin3_a: assert property (
    aen_q[3] |=> ANALOG_CHANNEL_CONNECT[3] && !CAPTURE_INPUT_ONE_VARIANT_B && !PAD_OE[3])
    else $error("pin 3 analog not selected");
  cmp2_drive_a: assert property (
    sel_q[4] && dir_q[4] && !aen_q[4] |=> PAD_OE[4] && PAD_OUT[4] == $past(TIMER_COMPARE_OUTPUT_TWO))
    else $error("compare output two not driven");
  analog_pin4_a: assert property (
    aen_q[4] |=> ANALOG_CHANNEL_CONNECT[4] && !PAD_OE[4])
    else $error("pin 4 analog not selected");
  gpio_pin5_a: assert property (
    !sel_q[5] && !osc_q[0] |=> PAD_OE[5] == $past(dir_q[5]) && !OSC_RESISTOR_CONNECT)
    else $error("pin 5 general I/O wrong");
  none_pin5_a: assert property (
    sel_q[5] && !dir_q[5] && !osc_q[0] |=> !PAD_OE[5] && !OSC_RESISTOR_CONNECT)
    else $error("pin 5 unexpected function");
  ground_pin5_a: assert property (
    sel_q[5] && dir_q[5] && !osc_q[0] |=> PAD_OE[5] && !PAD_OUT[5])
    else $error("pin 5 not grounded");
  rosc_pin5_a: assert property (
    osc_q[0] |=> OSC_RESISTOR_CONNECT && !PAD_OE[5] && !PAD_SCHMITT_EN[5])
    else $error("resistor not connected");
  gpio_pin6_a: assert property (
    !sel_q[6] |=> PAD_OE[6] == $past(dir_q[6]) && !CRYSTAL_OSCILLATOR_INPUT)
    else $error("pin 6 general I/O wrong");
  xtal_pin6_a: assert property (
    !RST && sel_q[6] |=> CRYSTAL_OSCILLATOR_INPUT && !PAD_OE[6])
    else $error("crystal input not selected");
  // Pad flops are still cleared at the release edge, so the pin 6 default shows one edge later
  xtal_reset_a: assert property (
    $fell(RST) |=> CRYSTAL_OSCILLATOR_INPUT && !PAD_OE[6] && PAD_SCHMITT_EN == 8'hBF)
    else $error("pin 6 not crystal input after reset");
  reset_default_a: assert property (
    $fell(RST) |-> sel_q == SEL_RST && dir_q == DIR_RST && aen_q == AEN_RST && osc_q == OSC_RST)
    else $error("control bits not at default after reset");
  pin_isolate_a: assert property (
    $stable(dir_q[1]) && $stable(sel_q[1]) && $stable(aen_q[1]) && $changed(dir_q[3]) |=> $stable(PAD_OE[1]))
    else $error("pin 1 disturbed by pin 3 control");

  tclk_use_c: cover property (sel_q[1] && !dir_q[1] && !aen_q[1] ##1 TIMER_EXTERNAL_INPUT_CLOCK);
  analog_use_c: cover property (aen_q[3] ##1 ANALOG_CHANNEL_CONNECT[3]);
  rosc_use_c: cover property (osc_q[0] ##1 OSC_RESISTOR_CONNECT);
  gpio_xtal_c: cover property (!sel_q[6] && dir_q[6] ##1 PAD_OE[6]);

endmodule

// file: prmux_board_model.sv
// Board circuitry seen by the port pads: a pad shows its own drive or the board level
`timescale 1ns/1ps

module prmux_board_model (
  input wire logic [prmux_pkg::PORT_W-1:0] pad_out,
  input wire logic [prmux_pkg::PORT_W-1:0] pad_oe,
  input wire logic [prmux_pkg::PORT_W-1:0] board_level,
  output logic [prmux_pkg::PORT_W-1:0] pad_in
);
  import prmux_pkg::*;
  // No pull resistors: an undriven pad follows whatever the board applies
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule

// file: port2_pin_function_mux_test.sv
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps

module port2_pin_function_mux_test;
  import prmux_pkg::*;
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] sch;
    logic [7:0] ana;
    logic tec;
    logic cap;
    logic crystal_oscillator_input;
    logic rosc;
  } prmux_exp_t;
  // ===========================================================================
  // Signals
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pad_req = 0;
  logic subsystem_main_clock = 0, cmp1 = 0, cmp2 = 0, pready, pslverr, tec, cap, crystal_oscillator_input, rosc;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] board = '0, pad_in, pad_out, pad_oe, pad_sch, ana;
  logic [7:0] s_dir, s_sel, s_aen, s_osc, s_out;
  logic [32:0] aq[$];
  prmux_exp_t pq[$];
  int error_cnt = 0, total_checks = 0;

  always #20 clk = ~clk;

  prmux_top u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_in), .PAD_OUT(pad_out),
    .PAD_OE(pad_oe), .PAD_SCHMITT_EN(pad_sch), .ANALOG_CHANNEL_CONNECT(ana), .SUBSYSTEM_MAIN_CLOCK(subsystem_main_clock),
    .TIMER_COMPARE_OUTPUT_ONE(cmp1), .TIMER_COMPARE_OUTPUT_TWO(cmp2), .TIMER_EXTERNAL_INPUT_CLOCK(tec),
    .CAPTURE_INPUT_ONE_VARIANT_B(cap), .CRYSTAL_OSCILLATOR_INPUT(crystal_oscillator_input), .OSC_RESISTOR_CONNECT(rosc));
  prmux_board_model u_board (.pad_out(pad_out), .pad_oe(pad_oe), .board_level(board), .pad_in(pad_in));

  // ===========================================================================
  // Checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Falling edge sampling keeps the monitor clear of the registered outputs' update
  always @(negedge clk) begin
    logic [32:0] a;
    prmux_exp_t e;
    if (pready === 1'b1 && aq.size() > 0) begin
      a = aq.pop_front();
      check({31'h0, pslverr}, {31'h0, a[32]}, "bus error");
      check(prdata, a[31:0], "read data");
    end
    if (pad_req === 1'b1 && pq.size() > 0) begin
      e = pq.pop_front();
      check({24'h0, pad_oe}, {24'h0, e.oe}, "drive enable");
      check({24'h0, pad_out & e.oe}, {24'h0, e.out & e.oe}, "pad value");
      check({24'h0, pad_sch}, {24'h0, e.sch}, "input buffer");
      check({24'h0, ana}, {24'h0, e.ana}, "analog switch");
      check({28'h0, tec, cap, crystal_oscillator_input, rosc}, {28'h0, e.tec, e.cap, e.crystal_oscillator_input, e.rosc}, "routed");
    end
  end

  // ===========================================================================
  // Expected pad behaviour
  function automatic prmux_exp_t model(input logic [7:0] b);
    prmux_exp_t e;
    logic [7:0] d, s, a;
    d = s_dir & 8'h7A;
    s = s_sel & 8'h7A;
    a = s_aen & 8'h1A;
    e = '0;
    e.sch = 8'hFF;
    e.oe = d;
    e.out = s_out;
    for (int i = 1; i < 5; i++) begin
      if (a[i]) begin
        e.oe[i] = 1'b0;
        e.sch[i] = 1'b0;
        e.ana[i] = 1'b1;
      end else if (s[i]) begin
        e.out[i] = (i == 1) ? subsystem_main_clock : (i == 3) ? cmp1 : cmp2;
      end
    end
    e.tec = s[1] & ~d[1] & ~a[1] & b[1];
    e.cap = s[3] & ~d[3] & ~a[3] & b[3];
    if (s_osc[0]) begin
      e.oe[5] = 1'b0;
      e.sch[5] = 1'b0;
      e.rosc = 1'b1;
    end else if (s[5]) begin
      e.out[5] = 1'b0;
    end
    if (s[6]) begin
      e.oe[6] = 1'b0;
      e.sch[6] = 1'b0;
      e.crystal_oscillator_input = 1'b1;
    end
    return e;
  endfunction

  // Input status register: pad level, gated off wherever the digital input buffer is off
  function automatic logic [7:0] in_exp(input logic [7:0] b);
    prmux_exp_t e;
    e = model(b);
    return ((e.oe & e.out) | (~e.oe & b)) & e.sch;
  endfunction

  // ===========================================================================
  // Drivers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
    aq.push_back(ex);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count is assumed here; the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic snap();
    pq.push_back(model(board));
    pad_req <= 1'b1;
    @(posedge clk);
    pad_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    s_dir = 8'h00;
    s_sel = 8'h40;
    s_aen = 8'h00;
    s_osc = 8'h00;
    s_out = 8'h00;
    repeat (2) @(posedge clk);
  endtask

  task automatic cfg(input logic [31:0] d, input logic [31:0] s, input logic [31:0] a, input logic [31:0] o,
                     input logic [31:0] q);
    board <= 8'($urandom());
    subsystem_main_clock <= 1'($urandom());
    cmp1 <= 1'($urandom());
    cmp2 <= 1'($urandom());
    apb(1'b1, DIR_OFS, d, 33'h0);
    apb(1'b1, SEL_OFS, s, 33'h0);
    apb(1'b1, AEN_OFS, a, 33'h0);
    apb(1'b1, OSC_OFS, o, 33'h0);
    apb(1'b1, OUT_OFS, q, 33'h0);
    s_dir = d[7:0];
    s_sel = s[7:0];
    s_aen = a[7:0];
    s_osc = o[7:0];
    s_out = q[7:0];
    repeat (4) @(posedge clk);
    snap();
    apb(1'b0, IN_OFS, 32'h0, {25'h000_0000, in_exp(board)});
  endtask

  // ===========================================================================
  // Tests
  initial begin
    void'($urandom(21));
    do_reset();
    snap();
    apb(1'b0, DIR_OFS, 32'h0, {1'b0, 32'h0000_0000});
    apb(1'b0, SEL_OFS, 32'h0, {1'b0, 32'h0000_0040});
    apb(1'b0, AEN_OFS, 32'h0, {1'b0, 32'h0000_0000});
    apb(1'b0, OSC_OFS, 32'h0, {1'b0, 32'h0000_0000});
    apb(1'b0, OUT_OFS, 32'h0, {1'b0, 32'h0000_0000});
    $display("test reset defaults done");
    cfg(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    apb(1'b0, DIR_OFS, 32'h0, {1'b0, 32'h0000_007A});
    apb(1'b0, SEL_OFS, 32'h0, {1'b0, 32'h0000_007A});
    apb(1'b0, AEN_OFS, 32'h0, {1'b0, 32'h0000_001A});
    apb(1'b0, OSC_OFS, 32'h0, {1'b0, 32'h0000_0001});
    // Refused accesses must leave the stored bits alone
    apb(1'b1, 8'h18, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b0, 8'h1C, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b0, DIR_OFS, 32'h0, {1'b0, 32'h0000_007A});
    $display("test masks and unmapped done");
    for (int c = 0; c < 16; c++) begin
      cfg({32{c[0]}}, {32{c[1]}}, {32{c[2]}}, {32{c[3]}}, 32'($urandom()));
    end
    $display("test mode table done");
    repeat (24) cfg($urandom(), $urandom(), $urandom(), $urandom(), $urandom());
    $display("test random modes done");
    cfg(32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF);
    do_reset();
    snap();
    $display("test mid-run reset done");
    give_verdict();
  end

  initial begin
    #800000;
    $display("watchdog expired");
    error_cnt++;
    give_verdict();
  end
endmodule
